// ### inc/apsc_pkg.sv
// apsc_pkg: register map, field positions, reset values and timing counts
// for the adc/pwm synchronisation control block.
// assumes an apb slave with 32-bit data; all offsets are byte addresses.
package apsc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_DIVA   = 8'h04;
   localparam logic [7:0] OFF_DIVB   = 8'h08;
   localparam logic [7:0] OFF_PHASE  = 8'h0C;
   localparam logic [7:0] OFF_CAL    = 8'h10;
   localparam logic [7:0] OFF_SETTLE = 8'h14;
   localparam logic [7:0] OFF_PWMPER = 8'h18;
   localparam logic [7:0] OFF_DATA0  = 8'h20;  // channel n at OFF_DATA0 + 4*n
   localparam logic [7:0] OFF_PWMCFG = 8'h34;
   // control register fields
   localparam int CTL_EXT_A   = 0;
   localparam int CTL_EXT_B   = 1;
   localparam int CTL_RD_A    = 2;
   localparam int CTL_RD_B    = 3;
   localparam int CTL_EXT_MUX_SEL0    = 4;
   localparam int CTL_SYNC_A  = 7;
   localparam int CTL_SYNC_B  = 8;
   localparam int CTL_BUSYSEL = 9;
   localparam int CTRL_W      = 16;
   localparam logic [15:0] CTRL_RST = 16'h0C00;  // bank power-down bits set
   // divider keeps bits 11:6 of the written value
   localparam int DIV_LSB = 6;
   localparam int DIV_MSB = 11;
   localparam logic [11:0] DIV_RST = 12'h180;
   localparam int PHASE_W  = 7;
   localparam int SLICES   = 128;
   localparam int CAL_W    = 5;
   localparam int NCH      = 5;
   localparam int NCH_A    = 2;      // channels 0..1 bank a, 2..4 bank b
   localparam int SINC_LEN = 64;
   localparam int SINC_ACC = 19;     // 1 + 3*log2(64)
   localparam int BUSY_PERIODS = 4;
   localparam int EXT_LAT  = 2;      // cycles from start edge to latch
   // interrupt vector addresses and priorities
   localparam logic [15:0] VEC_A = 16'h0030;
   localparam logic [15:0] VEC_B = 16'h0038;
   localparam int VEC_WORDS = 4;
   localparam int PRIO_A = 1;
   localparam int PRIO_B = 3;
endpackage

// ### hw/apsc_top.sv
// apsc_top: digital control of a two-bank sigma-delta adc: update timing,
// pwm lock with phase offset, calibration select, mux pins, busy flag.
// assumes pwm period pulse, start pin and modulator bits synchronous to clk_sys.
// Notes on behaviour
// - ctrl bit 7 locks bank a updates
// - ctrl bit 8 locks bank b independently
// - equal divider and period give per-period updates
// - seven-bit phase offset, 128 slices
// - strobe lands 128 minus offset slices later
// - phase shift only in single update mode
// - multiple rates stay locked to period pulse
// - offset counts fraction of adc period
// - results are 16-bit left-aligned two's complement
// - third-order sinc, length 64 decimation
// - five calibration bits, bit 0 channel 0
// - calibration ties channel inputs to reference
// - interrupt per bank after data update
// - no interrupt in continuous read mode
// - bank a top priority, vectors 0x30/0x38
// - ctrl bits 4-6 drive mux pins
// - settle bit 0 high while filters settle
// - ctrl bit 9 picks reported bank
// - ctrl, cal, phase writes start busy
// - selected bank divider write starts busy
// - data stays readable while busy
// - external start latches within two cycles
// - read mode refreshes at half clock
// - divider keeps bits 6 to 11
`timescale 1ns/1ps
module apsc_top (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire logic                      pwm_period_pulse,
   input  wire logic                      convert_start_strobe,
   input  wire logic [4:0]                mod_bit,
   output logic                           irq_bank_a,
   output logic                           irq_bank_b,
   output logic [4:0]                     cal_tie_ref,
   output logic [4:0]                     mod_clk_en,
   output logic                           ext_mux_sel0,
   output logic                           ext_mux_sel1,
   output logic                           ext_mux_sel2
);
   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] cnt;      // divide counter, counts cycles within update
      logic [11:0] sub;      // modulator rate sub-counter
      logic [1:0]  ext_pipe; // start-edge delay line
      logic        half;     // read-mode half-rate toggle
      logic        upd;      // data registers updated this cycle
      logic [2:0]  busy_n;   // remaining busy sample periods
      logic        busy;
   } apsc_bank_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [11:0] div_a;
      logic [11:0] div_b;
      logic [6:0]  phase;
      logic [4:0]  cal;
      logic [15:0] pwm_per;
      logic        dbl_upd;
      logic        start_d;
      apsc_bank_t  ba;
      apsc_bank_t  bb;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq_a;
      logic        irq_b;
      logic [4:0]  mclk;
   } apsc_state_t;

   // ----------------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------------
   logic rst_s1_r;
   logic rst_s2_r;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   apsc_state_t st_r;
   apsc_state_t st_nxt;
   logic [15:0] data_q [5];
   logic [15:0] filt_out [5];
   logic [4:0]  filt_dump;

   // ----------------------------------------------------------------------
   // sinc3 decimators, one per channel, dumped on its bank's update
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < apsc_pkg::NCH; gi++) begin : g_ch
         logic [18:0] i1_r, i2_r, i3_r, d1_r, d2_r, d3_r;
         logic [18:0] c1, c2, c3;
         logic [18:0] c3s;
         logic [18:0] inb;
         logic        tick;
         logic        dump;
         logic        alt_r;
         assign tick = st_r.mclk[gi];
         assign dump = filt_dump[gi];
         // calibration feeds a mid-scale stream; it toggles per tick, not per clock,
         // so banks with slower modulator ticks still see an even mix of ones
         assign inb = cal_tie_ref[gi] ? {18'h0, alt_r}
                                      : {18'h0, mod_bit[gi]};
         // integrators run at the modulator rate, combs at the update rate
         always_ff @(posedge clk_sys or negedge rst_s2_r) begin
            if (!rst_s2_r) begin
               i1_r <= 19'h0;
               i2_r <= 19'h0;
               i3_r <= 19'h0;
               d1_r <= 19'h0;
               d2_r <= 19'h0;
               d3_r <= 19'h0;
               alt_r <= 1'b0;
            end else begin
               if (tick) begin
                  alt_r <= ~alt_r;
                  i1_r <= i1_r + inb;
                  i2_r <= i2_r + i1_r;
                  i3_r <= i3_r + i2_r;
               end
               if (dump) begin
                  d1_r <= i3_r;
                  d2_r <= c1;
                  d3_r <= c2;
               end
            end
         end
         assign c1 = i3_r - d1_r;
         assign c2 = c1 - d2_r;
         assign c3 = c2 - d3_r;
         // mid-scale 2^17 maps to zero; full scale clips to the largest code
         assign c3s = c3 - 19'h20000;
         assign filt_out[gi] = c3[18] ? 16'h7FFF : c3s[17:2];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // per-bank timing: one function serves both banks
   // ----------------------------------------------------------------------
   function automatic apsc_bank_t bank_step(
      input apsc_bank_t  b,
      input logic [11:0] div,
      input logic        ext,
      input logic        rdm,
      input logic        sync,
      input logic [6:0]  phase,
      input logic        dbl,
      input logic        pulse,
      input logic        start_edge,
      input logic        wr_busy
   );
      apsc_bank_t  n;
      logic [11:0] slice;
      logic [11:0] align;
      logic [12:0] prod;
      logic        wrap;
      n = b;
      n.upd = 1'b0;
      slice = {6'h0, div[11:6]};                  // div/64, i.e. two slices
      // start phase slices into the period so the wrap, and the strobe with it,
      // falls (128 - phase) slices after the pulse; product is 13 bits wide
      prod = 13'(slice[5:0]) * 13'(phase);
      align = (dbl || phase == 7'h0) ? 12'h0 : prod[12:1];
      wrap = (b.cnt >= div - 12'h1);
      n.cnt = wrap ? 12'h0 : b.cnt + 12'h1;
      if (sync && pulse) begin
         // realign keeps integer-multiple rates locked too
         n.cnt = (dbl ? 12'h0 : align);
      end
      n.sub = (b.sub >= {6'h0, div[11:6]} - 12'h1 || wrap) ? 12'h0 : b.sub + 12'h1;
      n.ext_pipe = {b.ext_pipe[0], start_edge};
      n.half = ~b.half;
      if (rdm) begin
         n.upd = b.half;
      end else if (ext) begin
         n.upd = b.ext_pipe[0];
      end else begin
         n.upd = wrap || (sync && pulse && align == 12'h0 && !wrap);
      end
      // busy counts update periods of this bank
      if (wr_busy) begin
         n.busy_n = 3'(apsc_pkg::BUSY_PERIODS);
         n.busy = 1'b1;
      end else if (wrap && b.busy_n != 3'h0) begin
         n.busy_n = b.busy_n - 3'h1;
         n.busy = (b.busy_n != 3'h1);
      end
      return n;
   endfunction

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   logic        acc;
   logic        wr;
   logic        wr_any_cfg;
   logic        wr_a_busy;
   logic        wr_b_busy;
   logic [31:0] rd_mux;
   logic        hit;
   logic [2:0]  ch_idx;
   always_comb begin
      st_nxt = st_r;
      acc = psel && penable;
      wr = acc && pwrite;
      ch_idx = 3'(({24'h0, paddr} - {24'h0, apsc_pkg::OFF_DATA0}) >> 2);
      wr_any_cfg = wr && (paddr == apsc_pkg::OFF_CTRL || paddr == apsc_pkg::OFF_CAL
                       || paddr == apsc_pkg::OFF_PHASE);
      wr_a_busy = wr_any_cfg || (wr && paddr == apsc_pkg::OFF_DIVA
                  && !st_r.ctrl[apsc_pkg::CTL_BUSYSEL]);
      wr_b_busy = wr_any_cfg || (wr && paddr == apsc_pkg::OFF_DIVB
                  && st_r.ctrl[apsc_pkg::CTL_BUSYSEL]);
      // register writes
      if (wr) begin
         case (paddr)
            apsc_pkg::OFF_CTRL:   st_nxt.ctrl = pwdata[15:0];
            apsc_pkg::OFF_DIVA:   st_nxt.div_a = {pwdata[11:6], 6'h0};
            apsc_pkg::OFF_DIVB:   st_nxt.div_b = {pwdata[11:6], 6'h0};
            apsc_pkg::OFF_PHASE:  st_nxt.phase = pwdata[6:0];
            apsc_pkg::OFF_CAL:    st_nxt.cal = pwdata[4:0];
            apsc_pkg::OFF_PWMPER: st_nxt.pwm_per = pwdata[15:0];
            apsc_pkg::OFF_PWMCFG: st_nxt.dbl_upd = pwdata[0];
            default: ;
         endcase
      end
      st_nxt.start_d = convert_start_strobe;
      st_nxt.ba = bank_step(st_r.ba, st_r.div_a, st_r.ctrl[apsc_pkg::CTL_EXT_A],
                            st_r.ctrl[apsc_pkg::CTL_RD_A], st_r.ctrl[apsc_pkg::CTL_SYNC_A],
                            st_r.phase, st_r.dbl_upd, pwm_period_pulse,
                            convert_start_strobe && !st_r.start_d, wr_a_busy);
      st_nxt.bb = bank_step(st_r.bb, st_r.div_b, st_r.ctrl[apsc_pkg::CTL_EXT_B],
                            st_r.ctrl[apsc_pkg::CTL_RD_B], st_r.ctrl[apsc_pkg::CTL_SYNC_B],
                            st_r.phase, st_r.dbl_upd, pwm_period_pulse,
                            convert_start_strobe && !st_r.start_d, wr_b_busy);
      // modulator tick 64 times per update
      st_nxt.mclk = {{3{st_r.bb.sub == 12'h0}}, {2{st_r.ba.sub == 12'h0}}};
      // one-cycle interrupt pulses, suppressed in read mode; a outranks b
      st_nxt.irq_a = st_r.ba.upd && !st_r.ctrl[apsc_pkg::CTL_RD_A];
      st_nxt.irq_b = st_r.bb.upd && !st_r.ctrl[apsc_pkg::CTL_RD_B];
      // read mux; data stays readable at all times
      hit = 1'b1;
      case (paddr)
         apsc_pkg::OFF_CTRL:   rd_mux = {16'h0, st_r.ctrl};
         apsc_pkg::OFF_DIVA:   rd_mux = {20'h0, st_r.div_a};
         apsc_pkg::OFF_DIVB:   rd_mux = {20'h0, st_r.div_b};
         apsc_pkg::OFF_PHASE:  rd_mux = {25'h0, st_r.phase};
         apsc_pkg::OFF_CAL:    rd_mux = {27'h0, st_r.cal};
         apsc_pkg::OFF_SETTLE: rd_mux = {31'h0, st_r.ctrl[apsc_pkg::CTL_BUSYSEL]
                                         ? st_r.bb.busy : st_r.ba.busy};
         apsc_pkg::OFF_PWMPER: rd_mux = {16'h0, st_r.pwm_per};
         apsc_pkg::OFF_PWMCFG: rd_mux = {31'h0, st_r.dbl_upd};
         8'h20, 8'h24, 8'h28, 8'h2C, 8'h30:
                               rd_mux = {16'h0, data_q[ch_idx]};
         default: begin
            rd_mux = 32'h0;
            hit = 1'b0;
         end
      endcase
      // zero-wait apb: ready in the access cycle, registered on the setup cycle's closing edge
      st_nxt.pready = psel && !penable;
      st_nxt.pslverr = psel && !penable && !hit;
      if (psel && !penable) begin
         st_nxt.prdata = rd_mux;
      end
   end

   // ----------------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         st_r <= '0;
         st_r.ctrl <= apsc_pkg::CTRL_RST;
         st_r.div_a <= apsc_pkg::DIV_RST;
         st_r.div_b <= apsc_pkg::DIV_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // data registers latch the filter output on each bank update
   assign filt_dump = {{3{st_r.bb.upd}}, {2{st_r.ba.upd}}};
   always_ff @(posedge clk_sys or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         for (int i = 0; i < 5; i++) data_q[i] <= 16'h0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (filt_dump[i]) data_q[i] <= filt_out[i];
         end
      end
   end

   // calibration tie and mux pins follow their register bits directly
   logic [7:0] pin_r;
   always_ff @(posedge clk_sys or negedge rst_s2_r) begin
      if (!rst_s2_r) pin_r <= 8'h0;
      else pin_r <= {st_nxt.cal, st_nxt.ctrl[6:4]};
   end

   assign pready       = st_r.pready;
   assign prdata       = st_r.prdata;
   assign pslverr      = st_r.pslverr;
   assign irq_bank_a   = st_r.irq_a;
   assign irq_bank_b   = st_r.irq_b;
   assign mod_clk_en   = st_r.mclk;
   assign cal_tie_ref  = pin_r[7:3];
   assign ext_mux_sel0 = pin_r[0];
   assign ext_mux_sel1 = pin_r[1];
   assign ext_mux_sel2 = pin_r[2];

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_mux_follow;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      wr && paddr == apsc_pkg::OFF_CTRL |=> ##1 ext_mux_sel0 == $past(pwdata[4], 2);
   endproperty
   a_mux_follow: assert property (p_mux_follow) else $error("mux pin mismatch");

   property p_no_irq_rd;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      $past(st_r.ctrl[2]) |-> !irq_bank_a;
   endproperty
   a_no_irq_rd: assert property (p_no_irq_rd) else $error("irq in read mode");

   property p_irq_after_upd;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      irq_bank_a |-> $past(st_r.ba.upd);
   endproperty
   a_irq_after_upd: assert property (p_irq_after_upd) else $error("irq without update");

   property p_busy_set;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      wr && paddr == apsc_pkg::OFF_CAL |=> st_r.ba.busy && st_r.bb.busy;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set");

   property p_ext_lat;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      st_r.ctrl[0] && !st_r.ctrl[2] && convert_start_strobe && !st_r.start_d
      && $stable(st_r.ctrl) |-> ##[1:2] st_r.ba.upd;
   endproperty
   a_ext_lat: assert property (p_ext_lat) else $error("external start late");

   property p_div_mask;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      st_r.div_a[5:0] == 6'h0 && st_r.div_b[5:0] == 6'h0;
   endproperty
   a_div_mask: assert property (p_div_mask) else $error("divider low bits kept");

   property p_rd_half;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      st_r.ctrl[2] && $past(st_r.ctrl[2], 2) && st_r.ba.upd |=> !st_r.ba.upd;
   endproperty
   a_rd_half: assert property (p_rd_half) else $error("read mode rate wrong");

   property p_settle_sel;
      @(posedge clk_sys) disable iff (!rst_s2_r)
      psel && !penable && paddr == apsc_pkg::OFF_SETTLE |=>
      prdata[0] == $past(st_r.ctrl[9] ? st_r.bb.busy : st_r.ba.busy);
   endproperty
   a_settle_sel: assert property (p_settle_sel) else $error("busy select wrong");
endmodule

// ### verif/apsc_pwm_model.sv
// apsc_pwm_model: pwm timing unit model that issues the period pulse.
// assumes clk_sys drives both this model and the block; pulses are one cycle.
`timescale 1ns/1ps
module apsc_pwm_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        en,
   input  wire logic [15:0] period,
   input  wire logic        dbl,
   output logic             pwm_period_pulse
);
   logic [15:0] cnt_r;
   // ---------------------------------------------------------------
   // period counter
   // ---------------------------------------------------------------
   // pulse at each period start, plus midpoint in double update mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r            <= 16'h0000;
         pwm_period_pulse <= 1'b0;
      end else begin
         cnt_r            <= (cnt_r >= period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
         pwm_period_pulse <= en && (cnt_r == 16'h0000 || (dbl && cnt_r == period >> 1));
      end
   end
endmodule

// ### verif/adc_pwm_sync_control_bench.sv
// adc_pwm_sync_control_bench: apb driven tests of the adc/pwm sync block.
// assumes zero-wait apb slave and the pwm model on the period pulse input.
`timescale 1ns/1ps
module adc_pwm_sync_control_bench;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, irq_bank_a, irq_bank_b, pwm_period_pulse;
   logic [31:0] prdata, rd;
   logic        convert_start_strobe = 1'b0;
   logic [4:0]  mod_bit = 5'h00;
   logic [4:0]  cal_tie_ref, mod_clk_en;
   logic        ext_mux_sel0, ext_mux_sel1, ext_mux_sel2, err;
   logic        pwm_en = 1'b0;
   logic        pwm_dbl = 1'b0;
   logic [15:0] pwm_per = 16'h0040;
   int          miscompares = 0;
   int          check_count = 0;
   int          n, d0, d1, dq;
   apsc_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pwm_period_pulse(pwm_period_pulse),
      .convert_start_strobe(convert_start_strobe), .mod_bit(mod_bit),
      .irq_bank_a(irq_bank_a), .irq_bank_b(irq_bank_b), .cal_tie_ref(cal_tie_ref),
      .mod_clk_en(mod_clk_en), .ext_mux_sel0(ext_mux_sel0), .ext_mux_sel1(ext_mux_sel1),
      .ext_mux_sel2(ext_mux_sel2));
   apsc_pwm_model pwm_u (.clk_sys(clk_sys), .rst_b(rst_b), .en(pwm_en), .period(pwm_per),
      .dbl(pwm_dbl), .pwm_period_pulse(pwm_period_pulse));
   // ---------------------------------------------------------------
   // clock and modulator stimulus
   // ---------------------------------------------------------------
   always #12.5 clk_sys = ~clk_sys;
   // changing bitstream so the filters see activity
   always @(posedge clk_sys) mod_bit <= mod_bit + 5'h01;
   // ---------------------------------------------------------------
   // bus tasks and helpers
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge clk_sys); i++; end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin $display("Error pready exp 1 seen %b", pready); miscompares++; end
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin $display("Error %s exp %h seen %h", nm, e, g); miscompares++; end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input int w);
      repeat (w) @(posedge clk_sys);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   // cycles from a sampled period pulse to the bank's next interrupt
   task automatic lag(input int b, output int d);
      int i;
      i = 0;
      do begin @(posedge clk_sys); i++; end while (pwm_period_pulse !== 1'b1 && i < 400);
      d = 0;
      do begin @(posedge clk_sys); d++; end while ((b ? irq_bank_b : irq_bank_a) !== 1'b1 && d < 300);
   endtask
   // settle over two pulses so realignment has taken hold
   task automatic lag2(input int b, output int d);
      lag(b, dq);
      lag(b, d);
   endtask
   task automatic cnt_irq(input int b, input int cyc, output int c);
      c = 0;
      repeat (cyc) begin @(posedge clk_sys); if ((b ? irq_bank_b : irq_bank_a) === 1'b1) c++; end
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      #(60000 * 25);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdchk(apsc_pkg::OFF_CTRL, 32'h0C00, 0);
      rdchk(apsc_pkg::OFF_DIVA, 32'h0180, 0);
      rdchk(apsc_pkg::OFF_PHASE, 32'h0, 0);
      $display("test reset values done");
      apb(1'b1, apsc_pkg::OFF_DIVA, 32'h0FFF);
      rdchk(apsc_pkg::OFF_DIVA, 32'h0FC0, 0);
      apb(1'b1, apsc_pkg::OFF_PHASE, 32'h00FF);
      rdchk(apsc_pkg::OFF_PHASE, 32'h007F, 0);
      apb(1'b1, apsc_pkg::OFF_CAL, 32'h00FF);
      rdchk(apsc_pkg::OFF_CAL, 32'h001F, 0);
      chk("cal_tie_ref", 32'h1F, {27'h0, cal_tie_ref});
      apb(1'b1, apsc_pkg::OFF_CAL, 32'h0001);
      repeat (2) @(posedge clk_sys);
      chk("cal_tie_ref", 32'h01, {27'h0, cal_tie_ref});
      apb(1'b1, 8'h38, 32'hFFFF_FFFF);
      chk("unmapped write err", 32'h1, {31'h0, err});
      rdchk(8'h38, 32'h0, 0);
      chk("unmapped read err", 32'h1, {31'h0, err});
      $display("test fields done");
      for (int v = 0; v < 8; v++) begin
         apb(1'b1, apsc_pkg::OFF_CTRL, 32'(v) << 4);
         repeat (2) @(posedge clk_sys);
         chk("mux pins", 32'(v), {29'h0, ext_mux_sel2, ext_mux_sel1, ext_mux_sel0});
      end
      $display("test mux done");
      apb(1'b1, apsc_pkg::OFF_DIVA, 32'h0040);
      apb(1'b1, apsc_pkg::OFF_DIVB, 32'h0080);
      apb(1'b1, apsc_pkg::OFF_CAL, 32'h0000);
      apb(1'b1, apsc_pkg::OFF_PHASE, 32'h0000);
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h0000);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h1, 0);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h1, 150);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h0, 1200);
      apb(1'b1, apsc_pkg::OFF_CAL, 32'h0001);
      apb(1'b0, apsc_pkg::OFF_DATA0, 32'h0);
      chk("data read while busy err", 32'h0, {31'h0, err});
      rdchk(apsc_pkg::OFF_SETTLE, 32'h0, 600);
      // tied channel settles on mid-scale: that code is the offset to subtract
      rdchk(apsc_pkg::OFF_DATA0, 32'h0, 0);
      apb(1'b1, apsc_pkg::OFF_CAL, 32'h0000);
      apb(1'b1, apsc_pkg::OFF_DIVA, 32'h0040);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h1, 0);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h0, 600);
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h0200);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h0, 1200);
      apb(1'b1, apsc_pkg::OFF_DIVB, 32'h0080);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h1, 300);
      rdchk(apsc_pkg::OFF_SETTLE, 32'h0, 600);
      $display("test busy done");
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h0000);
      chk("mod_clk_en a", 32'h3, {30'h0, mod_clk_en[1:0]});
      n = 0;
      repeat (256) begin @(posedge clk_sys); if (mod_clk_en[2] === 1'b1) n++; end
      chk("bank b ticks near 128", 32'h1, {31'h0, n >= 127 && n <= 129});
      cnt_irq(0, 640, n);
      chk("irq a count near 10", 32'h1, {31'h0, n >= 9 && n <= 11});
      cnt_irq(1, 640, n);
      chk("irq b count near 5", 32'h1, {31'h0, n >= 4 && n <= 6});
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h000C);
      repeat (10) @(posedge clk_sys);
      cnt_irq(0, 640, n);
      chk("irq a in read mode", 32'h0, 32'(n));
      cnt_irq(1, 200, n);
      chk("irq b in read mode", 32'h0, 32'(n));
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h0003);
      repeat (10) @(posedge clk_sys);
      cnt_irq(0, 200, n);
      chk("irq a external idle", 32'h0, 32'(n));
      convert_start_strobe <= 1'b1;
      d0 = 0;
      do begin @(posedge clk_sys); d0++; end while (irq_bank_a !== 1'b1 && d0 < 50);
      chk("irq b external", 32'h1, {31'h0, irq_bank_b});
      convert_start_strobe <= 1'b0;
      chk("external latch lag ok", 32'h1, {31'h0, d0 <= apsc_pkg::EXT_LAT + 2});
      $display("test interrupts done");
      apb(1'b1, apsc_pkg::OFF_PWMPER, 32'h0040);
      rdchk(apsc_pkg::OFF_PWMPER, 32'h0040, 0);
      pwm_en <= 1'b1;
      apb(1'b1, apsc_pkg::OFF_DIVB, 32'h0040);
      apb(1'b1, apsc_pkg::OFF_CTRL, 32'h0180);
      lag2(0, d0);
      lag2(1, d1);
      chk("bank a lag small", 32'h1, {31'h0, d0 < 8});
      chk("bank b lag small", 32'h1, {31'h0, d1 < 8});
      apb(1'b1, apsc_pkg::OFF_PHASE, 32'h0020);
      lag2(0, n);
      chk("bank a phase lag", 32'((d0 + 48) % 64), 32'(n));
      lag2(1, n);
      chk("bank b phase lag", 32'((d1 + 48) % 64), 32'(n));
      apb(1'b1, apsc_pkg::OFF_PWMCFG, 32'h0001);
      pwm_dbl <= 1'b1;
      lag2(0, n);
      chk("double mode no shift", 32'(d0), 32'(n));
      apb(1'b1, apsc_pkg::OFF_PWMCFG, 32'h0000);
      pwm_dbl <= 1'b0;
      pwm_per <= 16'h00C0;
      apb(1'b1, apsc_pkg::OFF_PHASE, 32'h0000);
      lag2(0, n);
      chk("triple rate lag", 32'(d0), 32'(n));
      apb(1'b1, apsc_pkg::OFF_PHASE, 32'h0020);
      lag2(0, n);
      chk("triple rate phase lag", 32'((d0 + 48) % 64), 32'(n));
      $display("test sync done");
      end_sim();
   end
endmodule
